// *** design/hrxf_rx_fifo.sv ***
/*
  hrxf_rx_fifo: receive address filter and 32 byte receive FIFO with packet
  end tags, delayed packet status, byte counting, long frame cut-off and
  DMA request. Assumes the upstream deserialiser runs on clk_sys and gives
  one-cycle strobes; the reader pops with rd_strobe and sees data a cycle on.
*/
// Contract
// - two byte broadcast FE-like, then all ones
// - one byte broadcast 111111X1 or all ones
// - all comparators disabled accepts every packet
// - bit 5 byte count, bit 7 byte choice
// - bit 6 ignores first byte bit 1
// - compare once sixteen address bits collected
// - match id shown after last byte read
// - FIFO holds thirty-two bytes
// - data available cleared until count read
// - ninth tag bit on packet last byte
// - threshold flag when level at threshold
// - overrun drops new byte, never overwrites
// - end of packet flag tracks tagged bytes
// - DMA request on threshold or tag
// - request held off until count read
// - sixteen bit count copied at last byte
// - long frame cut and flagged
// - maximum length is setting plus three
// - empty packets report nothing
// - address mismatch discards, back to hunt
`timescale 1ns/1ps
module hrxf_rx_fifo #(
  parameter int DEPTH = hrxf_pkg::FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH),
  localparam int LW = AW + 1
) (
  // clock, reset, enable
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  // deserialiser side
  input  wire logic                frame_start,
  input  wire logic                addr_valid,
  input  wire logic [7:0]          addr_first,
  input  wire logic [7:0]          addr_second,
  input  wire logic                byte_valid,
  input  wire logic [7:0]          byte_data,
  input  wire logic                frame_end,
  // configuration
  input  wire logic [7:0]          addr_ctrl,
  input  wire logic [15:0]         addr_reg_0,
  input  wire logic [15:0]         addr_reg_1,
  input  wire logic [15:0]         addr_reg_2,
  input  wire logic [15:0]         addr_reg_3,
  input  wire logic [LW-1:0]       fifo_threshold,
  input  wire logic [15:0]         max_size_limit_setting,
  // reader side
  input  wire logic                rd_strobe,
  input  wire logic                rd_count_low,
  output logic [7:0]               rd_data,
  output logic [15:0]              byte_count,
  output logic [2:0]               match_id,
  output logic                     long_frame,
  // status and events
  output logic                     data_available,
  output logic                     threshold_reached,
  output logic                     packet_end_tag,
  output logic                     rx_dma_request_line,
  output logic                     thr_rise_pulse,
  output logic                     eop_set_pulse,
  output logic                     dav_rise_pulse,
  output logic                     overrun_pulse,
  output logic                     hunt_pulse,
  output logic [LW-1:0]            fifo_level
);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  localparam logic [LW-1:0] ONE_L  = LW'(1);
  localparam logic [LW-1:0] FULL_L = LW'(DEPTH);

  hrxf_pkg::hrxf_state_t state_reg;
  logic [15:0] cnt_reg;
  logic [2:0]  pkt_id_reg;
  logic        pend_valid_reg, pend_last_reg, pend_long_reg;
  logic [7:0]  pend_data_reg;
  logic [15:0] pend_cnt_reg;
  logic [2:0]  pend_id_reg;
  logic [7:0]  data_mem [DEPTH];
  logic        tag_mem  [DEPTH];
  logic        long_mem [DEPTH];
  logic [15:0] cnt_mem  [DEPTH];
  logic [2:0]  id_mem   [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [LW-1:0] level_reg, tag_cnt_reg;
  logic        hold_reg, dma_reg, thr_reg, dav_prev_reg;
  logic        m_any, m_off;
  logic [2:0]  m_id;
  logic        full, empty, do_pop, tag_pop, acc_byte, load_ok, do_push;
  logic        long_hit, thr_now, dav_now;
  logic [16:0] max_len;
  logic [15:0] cnt_inc, head_cnt;
  logic [2:0]  head_id;

  // ----------------------------------------------------------------------
  // address comparators
  // ----------------------------------------------------------------------
  hrxf_addr_match u_match (
    .addr_ctrl   (addr_ctrl),
    .addr_reg_0  (addr_reg_0),
    .addr_reg_1  (addr_reg_1),
    .addr_reg_2  (addr_reg_2),
    .addr_reg_3  (addr_reg_3),
    .addr_first  (addr_first),
    .addr_second (addr_second),
    .match_any   (m_any),
    .match_id    (m_id),
    .filter_off  (m_off)
  );

  // ----------------------------------------------------------------------
  // datapath conditions
  // ----------------------------------------------------------------------
  assign full     = level_reg == FULL_L;
  assign empty    = level_reg == '0;
  assign do_pop   = clk_en & rd_strobe & !empty;
  assign head_cnt = cnt_mem[rd_ptr_reg];
  assign head_id  = id_mem[rd_ptr_reg];
  assign tag_pop  = do_pop & tag_mem[rd_ptr_reg];
  assign acc_byte = clk_en & byte_valid & (state_reg == hrxf_pkg::HRXF_DATA);
  assign cnt_inc  = cnt_reg + 16'h0001;
  assign max_len  = {1'b0, max_size_limit_setting} + hrxf_pkg::LONG_OFFSET;
  assign long_hit = {1'b0, cnt_inc} == max_len;
  // the held byte leaves when the next arrives or once it is marked last
  assign do_push  = clk_en & pend_valid_reg & !full & (pend_last_reg | acc_byte);
  assign load_ok  = !pend_valid_reg | do_push;
  assign thr_now  = level_reg >= fifo_threshold;
  assign dav_now  = !empty & !hold_reg;

  // ----------------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= hrxf_pkg::HRXF_HUNT;
      pkt_id_reg <= hrxf_pkg::ID_RESET;
    end else if (clk_en) begin
      case (state_reg)
        hrxf_pkg::HRXF_HUNT: begin
          if (frame_start) state_reg <= hrxf_pkg::HRXF_ADDR;
        end
        hrxf_pkg::HRXF_ADDR: begin
          if (frame_end) begin
            state_reg <= hrxf_pkg::HRXF_HUNT;
          end else if (addr_valid) begin
            state_reg  <= (m_any | m_off) ? hrxf_pkg::HRXF_DATA : hrxf_pkg::HRXF_HUNT;
            pkt_id_reg <= m_id;
          end
        end
        hrxf_pkg::HRXF_DATA: begin
          if (frame_end) state_reg <= hrxf_pkg::HRXF_HUNT;
          else if (acc_byte && load_ok && long_hit) state_reg <= hrxf_pkg::HRXF_DROP;
        end
        hrxf_pkg::HRXF_DROP: begin
          if (frame_end) state_reg <= hrxf_pkg::HRXF_HUNT;
        end
        default: state_reg <= hrxf_pkg::HRXF_HUNT;
      endcase
      if (frame_start && state_reg != hrxf_pkg::HRXF_ADDR) state_reg <= hrxf_pkg::HRXF_ADDR;
    end
  end

  // discard and overrun event strobes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hunt_pulse    <= 1'b0;
      overrun_pulse <= 1'b0;
    end else if (clk_en) begin
      hunt_pulse    <= state_reg == hrxf_pkg::HRXF_ADDR && !frame_end && addr_valid
                       && !(m_any | m_off);
      overrun_pulse <= acc_byte & !load_ok;
    end
  end

  // ----------------------------------------------------------------------
  // packet byte counter and holding byte
  // ----------------------------------------------------------------------
  // count bytes placed
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= hrxf_pkg::CNT_RESET;
    end else if (clk_en) begin
      if (frame_start) cnt_reg <= hrxf_pkg::CNT_RESET;
      else if (acc_byte && load_ok) cnt_reg <= cnt_inc;
    end
  end

  // the last byte is only known at the closing flag, so one byte is held
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_valid_reg <= 1'b0;
      pend_last_reg  <= 1'b0;
      pend_long_reg  <= 1'b0;
      pend_data_reg  <= hrxf_pkg::DATA_RESET;
      pend_cnt_reg   <= hrxf_pkg::CNT_RESET;
      pend_id_reg    <= hrxf_pkg::ID_RESET;
    end else if (clk_en) begin
      if (acc_byte && load_ok) begin
        pend_valid_reg <= 1'b1;
        pend_last_reg  <= long_hit;
        pend_long_reg  <= long_hit;
        pend_data_reg  <= byte_data;
        pend_cnt_reg   <= cnt_inc;
        pend_id_reg    <= pkt_id_reg;
      end else begin
        if (do_push) pend_valid_reg <= 1'b0;
        if (frame_end && state_reg == hrxf_pkg::HRXF_DATA && cnt_reg != '0 && !do_push)
          pend_last_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // storage, nine bits plus delayed status per entry
  // ----------------------------------------------------------------------
  // thirty-two entries
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      data_mem[wr_ptr_reg] <= pend_data_reg;
      tag_mem[wr_ptr_reg]  <= pend_last_reg;
      long_mem[wr_ptr_reg] <= pend_long_reg;
      cnt_mem[wr_ptr_reg]  <= pend_cnt_reg;
      id_mem[wr_ptr_reg]   <= pend_id_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      level_reg   <= '0;
      tag_cnt_reg <= '0;
    end else if (clk_en) begin
      if (do_push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (do_pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      level_reg   <= level_reg + (do_push ? ONE_L : '0) - (do_pop ? ONE_L : '0);
      tag_cnt_reg <= tag_cnt_reg + ((do_push & pend_last_reg) ? ONE_L : '0)
                     - (tag_pop ? ONE_L : '0);
    end
  end

  // ----------------------------------------------------------------------
  // reader side: data and delayed packet status
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data    <= hrxf_pkg::DATA_RESET;
      byte_count <= hrxf_pkg::CNT_RESET;
      match_id   <= hrxf_pkg::ID_RESET;
      long_frame <= 1'b0;
    end else if (do_pop) begin
      rd_data <= data_mem[rd_ptr_reg];
      if (tag_pop) begin
        byte_count <= head_cnt;
        match_id   <= head_id;
        long_frame <= long_mem[rd_ptr_reg];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hold_reg <= 1'b0;
    else if (clk_en) begin
      if (tag_pop) hold_reg <= 1'b1;
      else if (rd_count_low) hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) dma_reg <= 1'b0;
    else if (clk_en) begin
      if (hold_reg || tag_pop || (do_pop && level_reg == ONE_L)) dma_reg <= 1'b0;
      else if (!empty && (thr_now || tag_cnt_reg != '0)) dma_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      thr_reg        <= 1'b0;
      thr_rise_pulse <= 1'b0;
      eop_set_pulse  <= 1'b0;
      dav_prev_reg   <= 1'b0;
      dav_rise_pulse <= 1'b0;
    end else if (clk_en) begin
      thr_reg        <= thr_now;
      thr_rise_pulse <= thr_now & !thr_reg;
      eop_set_pulse  <= do_push & pend_last_reg;
      dav_prev_reg   <= dav_now;
      dav_rise_pulse <= dav_now & !dav_prev_reg;
    end
  end

  assign data_available      = dav_now;
  assign threshold_reached   = thr_reg;
  assign packet_end_tag      = tag_cnt_reg != '0;
  assign rx_dma_request_line = dma_reg & !hold_reg;
  assign fifo_level          = level_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_level_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
    level_reg <= FULL_L && !(full && do_push))
    else $error("fifo level above depth or push while full");
  chk_tag_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tag_pop && !rd_count_low |=> hold_reg && !rx_dma_request_line && !data_available)
    else $error("request or data available not held after last byte");
  chk_count_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tag_pop |=> byte_count == $past(head_cnt))
    else $error("byte count not copied at last byte");
  chk_id_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tag_pop |=> match_id == $past(head_id))
    else $error("match id not shown at last byte");
  chk_eop_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    do_push && pend_last_reg |=> packet_end_tag && eop_set_pulse)
    else $error("end of packet flag not set");
  chk_thr_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en |=> thr_rise_pulse == $rose(thr_reg))
    else $error("threshold pulse out of step with flag");
  chk_long_cut: assert property (@(posedge clk_sys) disable iff (!rst_b)
    acc_byte && load_ok && long_hit |=> pend_last_reg && pend_long_reg
      && {1'b0, pend_cnt_reg} == max_len && state_reg == hrxf_pkg::HRXF_DROP)
    else $error("long frame not cut at maximum");
  chk_discard: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && state_reg == hrxf_pkg::HRXF_ADDR && addr_valid && !frame_end && !frame_start
      && !m_any && !m_off |=> state_reg == hrxf_pkg::HRXF_HUNT && hunt_pulse)
    else $error("mismatching packet not discarded");
  chk_empty_pkt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clk_en && frame_end && cnt_reg == '0 && !pend_valid_reg |=> !pend_valid_reg)
    else $error("empty packet produced data");
  chk_dma_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    do_pop && !do_push && level_reg == ONE_L |=> !rx_dma_request_line [*2])
    else $error("request stays up on empty fifo");

  cov_last_byte: cover property (@(posedge clk_sys) disable iff (!rst_b) tag_pop);
  cov_overrun: cover property (@(posedge clk_sys) disable iff (!rst_b) overrun_pulse);
  cov_long: cover property (@(posedge clk_sys) disable iff (!rst_b) acc_byte && long_hit);
  cov_discard: cover property (@(posedge clk_sys) disable iff (!rst_b) hunt_pulse);
endmodule : hrxf_rx_fifo

// *** design/hrxf_pkg.sv ***
/*
  hrxf_pkg: shared constants and types of the receive address filter and
  receive FIFO. Assumes no other package; every user names items in full.
*/
package hrxf_pkg;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W      = 16;
  localparam int N_CMP      = 5;   // four programmable + broadcast

  // ----------------------------------------------------------------------
  // address control field positions
  // ----------------------------------------------------------------------
  localparam int ACR_EN_LSB     = 0;  // bits 0..4 comparator enables
  localparam int ACR_ONE_BYTE   = 5;  // set: one byte address
  localparam int ACR_IGN_CR     = 6;  // set: bit 1 of first byte ignored
  localparam int ACR_SEL_SECOND = 7;  // one byte mode: compare second byte

  // ----------------------------------------------------------------------
  // broadcast patterns and masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] BCAST_TWO_FIRST = 8'hFE;  // 111111X0 with X = 1
  localparam logic [7:0] BCAST_ONE_FIRST = 8'hFF;  // 111111X1 with X = 1
  localparam logic [7:0] BCAST_SECOND    = 8'hFF;
  localparam logic [7:0] CR_MASK         = 8'hFD;
  localparam logic [7:0] ALL_BITS        = 8'hFF;

  // ----------------------------------------------------------------------
  // status codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]  ID_NO_FILTER = 3'h7;  // filtering off, all accepted
  localparam logic [2:0]  ID_RESET     = 3'h0;
  localparam logic [16:0] LONG_OFFSET  = 17'h00003;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [7:0]  DATA_RESET   = 8'h00;

  // receive sequencer
  typedef enum logic [1:0] {HRXF_HUNT, HRXF_ADDR, HRXF_DATA, HRXF_DROP} hrxf_state_t;
endpackage : hrxf_pkg

// *** design/hrxf_addr_match.sv ***
/*
  hrxf_addr_match: five address comparators, combinational.
  Assumes both address bytes are stable while addr_first/addr_second are
  sampled by the caller on its compare strobe.
*/
`timescale 1ns/1ps
module hrxf_addr_match (
  // configuration
  input  wire logic [7:0]  addr_ctrl,
  input  wire logic [15:0] addr_reg_0,
  input  wire logic [15:0] addr_reg_1,
  input  wire logic [15:0] addr_reg_2,
  input  wire logic [15:0] addr_reg_3,
  // received address
  input  wire logic [7:0]  addr_first,
  input  wire logic [7:0]  addr_second,
  // result
  output logic             match_any,
  output logic [2:0]       match_id,
  output logic             filter_off
);
  logic [15:0] ref_w [hrxf_pkg::N_CMP];
  logic [hrxf_pkg::N_CMP-1:0] hit;
  logic [7:0] first_mask;

  // ----------------------------------------------------------------------
  // comparator references: high byte is compared with the first byte
  // ----------------------------------------------------------------------
  // entries 0 to 3 programmable; entry 4 broadcast, one or two byte by ACR_ONE_BYTE
  assign ref_w[0] = addr_reg_0;
  assign ref_w[1] = addr_reg_1;
  assign ref_w[2] = addr_reg_2;
  assign ref_w[3] = addr_reg_3;
  assign ref_w[4] = {addr_ctrl[hrxf_pkg::ACR_ONE_BYTE] ? hrxf_pkg::BCAST_ONE_FIRST
                                                      : hrxf_pkg::BCAST_TWO_FIRST,
                     hrxf_pkg::BCAST_SECOND};
  assign first_mask = addr_ctrl[hrxf_pkg::ACR_IGN_CR] ? hrxf_pkg::CR_MASK
                                                      : hrxf_pkg::ALL_BITS;

  // ----------------------------------------------------------------------
  // one comparator per entry
  // ----------------------------------------------------------------------
  // byte mode select
  for (genvar g = 0; g < hrxf_pkg::N_CMP; g++) begin : g_cmp
    logic f_ok;
    logic s_ok;
    assign f_ok = ((addr_first ^ ref_w[g][15:8]) & first_mask) == 8'h00;
    assign s_ok = addr_second == ref_w[g][7:0];
    assign hit[g] = addr_ctrl[hrxf_pkg::ACR_EN_LSB+g] &
                    (!addr_ctrl[hrxf_pkg::ACR_ONE_BYTE] ? (f_ok & s_ok) :
                     addr_ctrl[hrxf_pkg::ACR_SEL_SECOND] ? s_ok : f_ok);
  end

  assign filter_off = addr_ctrl[hrxf_pkg::ACR_EN_LSB +: hrxf_pkg::N_CMP] == 5'h00;
  assign match_any  = |hit;

  // lowest numbered hit wins when several match
  always_comb begin
    match_id = filter_off ? hrxf_pkg::ID_NO_FILTER : hrxf_pkg::ID_RESET;
    for (int i = hrxf_pkg::N_CMP - 1; i >= 0; i--) begin
      if (hit[i]) begin
        match_id = 3'(i);
      end
    end
  end
endmodule : hrxf_addr_match

// *** tb/hrxf_reader.sv ***
/*
  hrxf_reader: host model that unloads the receive FIFO and then reads the
  count low byte. Assumes rd_data is valid the cycle after rd_strobe.
*/
`timescale 1ns/1ps
module hrxf_reader (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // bench control
  input  wire logic       go,
  input  wire logic       slow,
  // device side
  input  wire logic       data_available,
  input  wire logic [7:0] rd_data,
  output logic            rd_strobe,
  output logic            rd_count_low
);
  logic [7:0] got[$];
  logic       pend;
  int         wt;
  // pops at most one byte in three cycles; a slow host lingers over status
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_strobe    <= 1'b0;
      rd_count_low <= 1'b0;
      pend         <= 1'b0;
      wt           <= 0;
    end else begin
      pend         <= rd_strobe;
      rd_count_low <= 1'b0;
      if (pend) begin
        got.push_back(rd_data);
      end
      rd_strobe <= go && data_available && !rd_strobe && !pend;
      if (go && !data_available && !rd_strobe && !pend) begin
        wt <= wt + 1;
        if (wt >= (slow ? 20 : 1)) begin
          rd_count_low <= 1'b1;
          wt           <= 0;
        end
      end
    end
  end
endmodule : hrxf_reader

// *** tb/hrxf_rx_fifo_test.sv ***
/*
  hrxf_rx_fifo_test: self-checking bench of the receive filter and FIFO.
  Assumes the reader model drains the FIFO whenever go is high.
*/
`timescale 1ns/1ps
module hrxf_rx_fifo_test;
  logic        clk_sys, rst_b, frame_start, addr_valid, byte_valid, frame_end;
  logic        go, slow, rd_strobe, rd_count_low, long_frame, data_available;
  logic        clk_en, dav_rise_pulse;
  logic        threshold_reached, packet_end_tag, rx_dma_request_line;
  logic        thr_rise_pulse, eop_set_pulse, overrun_pulse, hunt_pulse;
  logic [7:0]  addr_first, addr_second, byte_data, addr_ctrl, rd_data;
  logic [15:0] addr_reg_0, addr_reg_1, max_size_limit_setting, byte_count;
  logic [5:0]  fifo_threshold, fifo_level;
  logic [2:0]  match_id;
  logic [31:0] seed = 32'h59BBE1B4;
  logic [31:0] tbl[11] = '{32'h01123410, 32'h01123500, 32'h10FEFF14, 32'h10FCFF00,
    32'h50FCFF14, 32'h30FF0014, 32'hB000FF14, 32'h21129910, 32'hA1993410,
    32'h00556617, 32'h42A7C311};
  logic [7:0]  exp[$];
  int          n_fail = 0, checks_done = 0, cyc = 0, hunts = 0, eops = 0, ovr = 0;
  int          i, n, h;
  int          thr_ups = 0, dav_ups = 0;
  hrxf_rx_fifo dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .frame_start(frame_start), .addr_valid(addr_valid), .addr_first(addr_first),
    .addr_second(addr_second), .byte_valid(byte_valid), .byte_data(byte_data),
    .frame_end(frame_end), .addr_ctrl(addr_ctrl), .addr_reg_0(addr_reg_0),
    .addr_reg_1(addr_reg_1), .addr_reg_2(16'h0F0F), .addr_reg_3(16'h7E81),
    .fifo_threshold(fifo_threshold), .max_size_limit_setting(max_size_limit_setting),
    .rd_strobe(rd_strobe), .rd_count_low(rd_count_low), .rd_data(rd_data),
    .byte_count(byte_count), .match_id(match_id), .long_frame(long_frame),
    .data_available(data_available), .threshold_reached(threshold_reached),
    .packet_end_tag(packet_end_tag), .rx_dma_request_line(rx_dma_request_line),
    .thr_rise_pulse(thr_rise_pulse), .eop_set_pulse(eop_set_pulse),
    .dav_rise_pulse(dav_rise_pulse), .overrun_pulse(overrun_pulse), .hunt_pulse(hunt_pulse),
    .fifo_level(fifo_level));
  hrxf_reader rdr_u (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .slow(slow),
    .data_available(data_available), .rd_data(rd_data), .rd_strobe(rd_strobe),
    .rd_count_low(rd_count_low));
  // ----------------------------------------------------------------------
  // clock, event counters and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc   <= cyc + 1;
    hunts <= hunts + hunt_pulse;
    eops  <= eops + eop_set_pulse;
    ovr   <= ovr + overrun_pulse;
    thr_ups <= thr_ups + thr_rise_pulse;
    dav_ups <= dav_ups + dav_rise_pulse;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [15:0] a, input logic [15:0] b, input string m);
    checks_done++;
    if (a !== b) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, a, b);
    end
  endtask : chk
  // one frame: n bytes sent, first keep of them expected in the FIFO
  task automatic send(input logic [7:0] a1, input logic [7:0] a2, input int n, input int keep);
    logic [7:0] x;
    @(posedge clk_sys) frame_start <= 1'b1;
    @(posedge clk_sys) frame_start <= 1'b0;
    addr_valid  <= 1'b1;
    addr_first  <= a1;
    addr_second <= a2;
    @(posedge clk_sys) addr_valid <= 1'b0;
    for (int k = 0; k < n; k++) begin
      x = 8'(rnd());
      if (k < keep) exp.push_back(x);
      byte_data  <= x;
      byte_valid <= 1'b1;
      @(posedge clk_sys);
    end
    byte_valid <= 1'b0;
    frame_end  <= 1'b1;
    @(posedge clk_sys) frame_end <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : send
  task automatic drain(input logic [15:0] cnt, input logic [2:0] id);
    int k;
    k = 0;
    while (rdr_u.got.size() < exp.size() && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    chk(byte_count, cnt, "byte count");
    chk({13'h0000, match_id}, {13'h0000, id}, "match id");
    chk(16'(rdr_u.got.size()), 16'(exp.size()), "bytes read");
    for (k = 0; k < exp.size() && k < rdr_u.got.size(); k++) chk(rdr_u.got[k], exp[k], "data");
    exp.delete();
    rdr_u.got.delete();
  endtask : drain
  task automatic results();
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b, frame_start, addr_valid, byte_valid, frame_end, go, slow} = 7'h00;
    clk_en = 1'b1;
    {addr_first, addr_second, byte_data, addr_ctrl} = 32'h00000000;
    addr_reg_0 = 16'h1234;
    addr_reg_1 = 16'hA5C3;
    fifo_threshold = 6'h10;
    max_size_limit_setting = 16'h00FF;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys) go <= 1'b1;
    chk({fifo_level, rx_dma_request_line, data_available, packet_end_tag}, 16'h0000, "reset");
    // address modes, random lengths and data
    for (i = 0; i < 11; i++) begin
      n = 1 + rnd() % 6;
      h = hunts;
      @(posedge clk_sys) addr_ctrl <= tbl[i][31:24];
      send(tbl[i][23:16], tbl[i][15:8], n, tbl[i][4] ? n : 0);
      if (tbl[i][4]) drain(16'(n), tbl[i][2:0]);
      else chk(16'(hunts - h + fifo_level), 16'h0001, "mismatch kept");
    end
    h = eops;
    addr_ctrl <= 8'h01;
    send(8'h12, 8'h34, 0, 0);
    chk(16'(eops - h + fifo_level), 16'h0000, "empty frame");
    max_size_limit_setting <= 16'h0000;
    send(8'h12, 8'h34, 5, 3);
    drain(16'h0003, 3'h0);
    chk({15'h0000, long_frame}, 16'h0001, "long frame");
    max_size_limit_setting <= 16'h00FF;
    go <= 1'b0;
    h = ovr;
    n = thr_ups;
    send(8'h12, 8'h34, 34, 33);
    chk({fifo_level, threshold_reached, rx_dma_request_line}, {6'd32, 2'h3}, "full");
    chk(16'(ovr - h), 16'h0001, "overrun");
    chk(16'(thr_ups - n), 16'h0001, "threshold rise");
    go <= 1'b1;
    drain(16'd33, 3'h0);
    go   <= 1'b0;
    slow <= 1'b1;
    h = dav_ups;
    send(8'h12, 8'h34, 2, 2);
    send(8'h12, 8'h34, 3, 3);
    chk({14'h0000, rx_dma_request_line, packet_end_tag}, 16'h0003, "tag");
    chk(16'(dav_ups - h), 16'h0001, "data available rise");
    // a frame sent while the enable is low must leave no trace
    h = eops;
    clk_en <= 1'b0;
    send(8'h12, 8'h34, 2, 0);
    clk_en <= 1'b1;
    chk(16'(eops - h + fifo_level), 16'h0005, "frozen");
    go <= 1'b1;
    while (rdr_u.got.size() < 2 && cyc < 29000) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk({data_available, rx_dma_request_line, 6'(fifo_level)}, 16'h0003, "hold");
    drain(16'h0003, 3'h0);
    results();
  end
endmodule : hrxf_rx_fifo_test
